/* src/decade_counter.sv */
// bcd up/down decade counter stage with preset and ripple carry
`timescale 1ns/10ps
module decade_counter
  import decade_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  decade_if.dev PINS,
  output logic [3:0] COUNT_Q,
  output logic LIMIT,
  output logic CARRY_N,
  output logic [1:0] MODE,
  output logic STEP,
  output logic WRAP
);

  typedef struct packed {
    logic [3:0] count;
    logic clk_prev;
    logic carry_n;
    logic step;
    logic wrap;
    logic [1:0] mode;
  } state_t;

  localparam state_t STATE_RESET = '{
    count: RESET_COUNT,
    clk_prev: 1'b0,
    carry_n: 1'b1,
    step: 1'b0,
    wrap: 1'b0,
    mode: MODE_HOLD
  };

  state_t state_r;
  state_t state_nxt;

  logic rise;
  logic [3:0] shown;
  logic limit;
  mode_t mode;
  logic carry_pin_n;

  // next digit upward as a full table, so every code has a known successor;
  // invalid codes fall back into range in one step
  function automatic logic [3:0] bcd_up(input logic [3:0] d);
    logic [3:0] r;
    case (d)
      4'h0: r = 4'h1;
      4'h1: r = 4'h2;
      4'h2: r = 4'h3;
      4'h3: r = 4'h4;
      4'h4: r = 4'h5;
      4'h5: r = 4'h6;
      4'h6: r = 4'h7;
      4'h7: r = 4'h8;
      4'h8: r = DIGIT_MAX;
      DIGIT_MAX: r = DIGIT_MIN; // [R17]
      default: r = DIGIT_MIN; // [R18]
    endcase
    return r;
  endfunction

  // next digit downward, mirrored table;
  // invalid codes land on nine so the limit decode stays quiet
  function automatic logic [3:0] bcd_down(input logic [3:0] d);
    logic [3:0] r;
    case (d)
      DIGIT_MIN: r = DIGIT_MAX; // [R17]
      4'h1: r = DIGIT_MIN;
      4'h2: r = 4'h1;
      4'h3: r = 4'h2;
      4'h4: r = 4'h3;
      4'h5: r = 4'h4;
      4'h6: r = 4'h5;
      4'h7: r = 4'h6;
      4'h8: r = 4'h7;
      DIGIT_MAX: r = 4'h8;
      default: r = DIGIT_MAX; // [R18]
    endcase
    return r;
  endfunction

  // the clock pin is sampled on MCLK; a low-to-high change is one count edge
  assign rise = PINS.clock_in & ~state_r.clk_prev; // [R4]

  // preset shows at once without waiting for MCLK, like the asynchronous pin
  always_comb
  begin
    shown = state_r.count;
    if (!PINS.load_n)
    begin
      shown = PINS.preset_value; // [R2]
    end
  end

  // decoded from shown state and direction only, so it tracks both at once
  always_comb
  begin
    limit = 1'b0;
    if (PINS.direction == DIR_UP)
    begin
      limit = (shown == DIGIT_MAX); // [R6] [R8]
    end
    else
    begin
      limit = (shown == DIGIT_MIN); // [R6] [R7]
    end
  end

  // load outranks enable; direction only matters while counting
  always_comb
  begin
    mode = MODE_HOLD;
    if (!PINS.load_n)
    begin
      mode = MODE_LOAD;
    end
    else if (!PINS.enable_n)
    begin
      mode = MODE_DOWN; // [R5]
      if (PINS.direction == DIR_UP)
      begin
        mode = MODE_UP; // [R5]
      end
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.clk_prev = PINS.clock_in;
    state_nxt.step = 1'b0;
    state_nxt.wrap = 1'b0;
    state_nxt.mode = mode;
    unique case (mode)
      MODE_LOAD:
      begin
        state_nxt.count = PINS.preset_value; // [R2]
      end
      MODE_HOLD:
      begin
        state_nxt.count = state_r.count; // [R3]
      end
      MODE_UP:
      begin
        if (rise)
        begin
          state_nxt.count = bcd_up(state_r.count); // [R1] [R4] [R5]
          state_nxt.step = 1'b1;
          state_nxt.wrap = (state_r.count == DIGIT_MAX); // [R17]
        end
      end
      MODE_DOWN:
      begin
        if (rise)
        begin
          state_nxt.count = bcd_down(state_r.count); // [R1] [R4] [R5]
          state_nxt.step = 1'b1;
          state_nxt.wrap = (state_r.count == DIGIT_MIN); // [R17]
        end
      end
    endcase
    // low only in the clock-low phase of an enabled terminal count;
    // the registered form trades one MCLK of lag for a glitch-free pin
    state_nxt.carry_n = 1'b1; // [R11]
    if (PINS.load_n && !PINS.enable_n && limit)
    begin
      state_nxt.carry_n = PINS.clock_in; // [R9]
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_r <= STATE_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // load and enable act on the pin at once, as on an asynchronous part;
  // only the pulse itself waits for the registered copy
  always_comb
  begin
    carry_pin_n = state_r.carry_n;
    if (!PINS.load_n || PINS.enable_n)
    begin
      carry_pin_n = 1'b1; // [R10] [R11]
    end
  end

  // shown count bypasses the register while preset is held
  assign PINS.count_value = shown;
  assign PINS.limit_flag = limit;
  assign PINS.carry_pulse_n = carry_pin_n;

  // register views for the system side, plus the live limit decode and gated carry pin
  assign COUNT_Q = state_r.count;
  assign LIMIT = limit;
  assign CARRY_N = carry_pin_n;
  assign MODE = state_r.mode;
  assign STEP = state_r.step;
  assign WRAP = state_r.wrap;

endmodule // decade_counter

/* src/decade_pkg.sv */
// shared constants and types for the bcd up/down decade counter and its driver
// Operation
// [R1] four-bit 8421 bcd reversible modulo-ten state
// [R2] load_n low copies preset, overriding everything
// [R3] enable high holds count on every edge
// [R4] enable low advances on clock_in rising edge
// [R5] direction low counts up, high down
// [R6] limit high at nine up, zero down
// [R7] limit stays until state or direction changes
// [R8] limit ignores own enable input
// [R9] carry low during clock low phase
// [R10] enable high forces carry pulse high
// [R11] load or no limit holds carry high
// [R12] ripple chain: carry feeds next clock
// [R13] shared clock: low phase covers ripple
// [R14] gated chain: enables combine limits, global
// [R15] never clock from limit flag
// [R16] enable, direction stable around rising edge
// [R17] wrap nine to zero, zero to nine
// [R18] codes ten to fifteen return quickly
package decade_pkg;

  localparam logic [3:0] DIGIT_MIN = 4'h0;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] RESET_COUNT = 4'h0;
  localparam logic DIR_UP = 1'b0;
  localparam logic DIR_DOWN = 1'b1;

  // link clock half period, in ns and in MCLK cycles
  localparam int MCLK_NS = 20;
  localparam int LINK_HALF_NS = 100;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS / MCLK_NS < 1) ? 1 : LINK_HALF_NS / MCLK_NS;
  localparam logic [2:0] HALF_LAST = 3'(LINK_HALF_CYC - 1);

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_UP = 2'b01,
    MODE_DOWN = 2'b10,
    MODE_LOAD = 2'b11
  } mode_t;

endpackage

/* src/decade_if.sv */
// pin bundle between the counter stage and the system logic driving it
`timescale 1ns/10ps
interface decade_if;
  logic clock_in;
  logic load_n;
  logic enable_n;
  logic direction;
  logic [3:0] preset_value;
  logic [3:0] count_value;
  logic limit_flag;
  logic carry_pulse_n;

  modport dev (
    input clock_in,
    input load_n,
    input enable_n,
    input direction,
    input preset_value,
    output count_value,
    output limit_flag,
    output carry_pulse_n
  );

  modport sys (
    output clock_in,
    output load_n,
    output enable_n,
    output direction,
    output preset_value,
    input count_value,
    input limit_flag,
    input carry_pulse_n
  );
endinterface

/* src/decade_driver.sv */
// system-side logic that clocks, steers and presets one counter stage
`timescale 1ns/10ps
module decade_driver
  import decade_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  decade_if.sys PINS,
  input wire logic RUN,
  input wire logic DOWN,
  input wire logic LOAD_REQ,
  input wire logic [3:0] PRESET,
  output logic [3:0] COUNT,
  output logic LIMIT,
  output logic CASCADE_EN,
  output logic CASCADE_CLK
);

  typedef struct packed {
    logic [2:0] div;
    logic clk;
    logic enable_n;
    logic dir;
    logic load_n;
    logic load_pend;
    logic [3:0] preset;
  } state_t;

  localparam state_t STATE_RESET = '{
    div: 3'h0,
    clk: 1'b0,
    enable_n: 1'b1,
    dir: DIR_UP,
    load_n: 1'b1,
    load_pend: 1'b0,
    preset: RESET_COUNT
  };

  state_t state_r;
  state_t state_nxt;
  logic half_end;

  assign half_end = (state_r.div == HALF_LAST);

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.div = half_end ? 3'h0 : 3'(state_r.div + 3'h1);
    if (LOAD_REQ)
    begin
      state_nxt.load_pend = 1'b1;
      state_nxt.preset = PRESET;
    end
    if (half_end)
    begin
      state_nxt.clk = ~state_r.clk;
      // steering changes only as the clock falls, far from the rising edge
      if (state_r.clk)
      begin
        state_nxt.enable_n = ~RUN; // [R16]
        state_nxt.dir = DOWN; // [R16]
        state_nxt.load_n = ~state_r.load_pend;
        if (state_r.load_pend && !LOAD_REQ)
        begin
          state_nxt.load_pend = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_r <= STATE_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign PINS.clock_in = state_r.clk;
  assign PINS.load_n = state_r.load_n;
  assign PINS.enable_n = state_r.enable_n;
  assign PINS.direction = state_r.dir;
  assign PINS.preset_value = state_r.preset;

  assign COUNT = PINS.count_value;
  assign LIMIT = PINS.limit_flag;
  // next stage enable carries the global term, never the flag as a clock
  assign CASCADE_EN = RUN & PINS.limit_flag; // [R14] [R15]
  // ripple chains clock the next stage from the carry pin
  assign CASCADE_CLK = PINS.carry_pulse_n; // [R12] [R13]

endmodule // decade_driver

/* tb/decade_chk.sv */
// assertions on the counter link pins
`timescale 1ns/10ps
module decade_chk (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic clock_in,
  input wire logic load_n,
  input wire logic enable_n,
  input wire logic direction,
  input wire logic [3:0] preset_value,
  input wire logic [3:0] count_value,
  input wire logic limit_flag,
  input wire logic carry_pulse_n
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic prev_r;
  logic go;
  // own edge detect so the count checks see the same rise as the stage
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
      prev_r <= 1'b0;
    else
      prev_r <= clock_in;
  assign go = load_n && !enable_n && clock_in && !prev_r;
  chk_limit_decode: assert property (
    limit_flag == (count_value == (direction ? 4'h0 : 4'h9))) else $error("limit wrong");
  chk_load_shows: assert property (
    !load_n |-> count_value == preset_value) else $error("preset not shown");
  chk_count_hold: assert property (
    load_n && !go ##1 load_n |-> $stable(count_value)) else $error("count moved");
  chk_count_up: assert property (go && !direction ##1 load_n |->
    count_value == ($past(count_value) >= 4'h9 ? 4'h0 : $past(count_value) + 4'h1))
    else $error("up step wrong");
  chk_count_down: assert property (go && direction ##1 load_n |->
    count_value == (($past(count_value) - 4'h1) > 4'h9 ? 4'h9 : $past(count_value) - 4'h1))
    else $error("down step wrong");
  chk_digit_range: assert property (
    go ##1 load_n |-> count_value <= 4'h9) else $error("count out of range");
  chk_carry_idle: assert property (
    enable_n || !load_n || !limit_flag || clock_in |=> carry_pulse_n) else $error("carry low");
  chk_carry_pulse: assert property (
    !enable_n && load_n && limit_flag && !clock_in |=> !carry_pulse_n) else $error("no carry");
  chk_carry_forced: assert property (
    enable_n || !load_n |-> carry_pulse_n) else $error("carry not forced high");
  cover property (go && !direction && count_value == 4'h9);
  cover property (go && direction && count_value == 4'h0);
  cover property (!carry_pulse_n);
endmodule // decade_chk

/* tb/tb_top.sv */
// driver and counter stage back to back, checked at the user ports
`timescale 1ns/10ps
module tb_top;
  import decade_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic down = 1'b0;
  logic load_req = 1'b0;
  logic [3:0] preset = 4'h0;
  logic [3:0] count;
  logic [3:0] count_q;
  logic limit;
  logic carry_n;
  logic step;
  logic wrap;
  logic [1:0] mode;
  logic sys_limit;
  logic casc_en;
  logic casc_clk;
  int carry_lows = 0;
  int casc_lows = 0;
  int base = 0;
  int casc_base = 0;
  logic [3:0] e = 4'h0;
  int fail_count = 0;
  int checked = 0;
  decade_if ifc ();
  decade_driver u_decade_driver (.MCLK(mclk), .RST(rst), .PINS(ifc.sys), .RUN(run),
    .DOWN(down), .LOAD_REQ(load_req), .PRESET(preset), .COUNT(count), .LIMIT(sys_limit),
    .CASCADE_EN(casc_en), .CASCADE_CLK(casc_clk));
  decade_counter u_decade_counter (.MCLK(mclk), .RST(rst), .PINS(ifc.dev), .COUNT_Q(count_q),
    .LIMIT(limit), .CARRY_N(carry_n), .MODE(mode), .STEP(step), .WRAP(wrap));
  decade_chk u_decade_chk (.MCLK(mclk), .RST(rst), .clock_in(ifc.clock_in),
    .load_n(ifc.load_n), .enable_n(ifc.enable_n), .direction(ifc.direction),
    .preset_value(ifc.preset_value), .count_value(ifc.count_value),
    .limit_flag(ifc.limit_flag), .carry_pulse_n(ifc.carry_pulse_n));
  always #10 mclk = ~mclk;
  always @(negedge mclk)
  begin
    if (carry_n === 1'b0)
      carry_lows++;
    if (casc_clk === 1'b0)
      casc_lows++;
  end
  task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_step;
    int i;
    @(negedge mclk);
    for (i = 0; i < 40 && step !== 1'b1; i++)
      @(negedge mclk);
    if (step !== 1'b1)
    begin
      fail_count++;
      stop_test();
    end
  endtask
  // load waits on the pin itself: the request lands only at a link clock fall
  task automatic load(input logic [3:0] d);
    int i;
    preset = d;
    load_req = 1'b1;
    @(negedge mclk);
    load_req = 1'b0;
    for (i = 0; i < 40 && ifc.load_n !== 1'b0; i++)
      @(negedge mclk);
    if (ifc.load_n !== 1'b0)
    begin
      fail_count++;
      stop_test();
    end
    cmp("shown preset", d, count);
    for (i = 0; i < 40 && ifc.load_n !== 1'b1; i++)
      @(negedge mclk);
    if (ifc.load_n !== 1'b1)
    begin
      fail_count++;
      stop_test();
    end
    cmp("held preset", d, count_q);
    cmp("mode load", {2'h0, MODE_LOAD}, {2'h0, mode});
    e = d;
  endtask
  // run drops right after the last step, before the next fall samples it
  task automatic run_steps(input logic dn, input int n);
    int k;
    logic [3:0] p;
    down = dn;
    repeat (25) @(negedge mclk);
    run = 1'b1;
    for (k = 0; k < n; k++)
    begin
      p = e;
      if (dn)
        e = (e - 4'h1 > 4'h9) ? 4'h9 : e - 4'h1;
      else
        e = (e >= 4'h9) ? 4'h0 : e + 4'h1;
      wait_step();
      if (k == n - 1)
        run = 1'b0;
      cmp("count", e, count_q);
      cmp("wrap", {3'h0, p == (dn ? 4'h0 : 4'h9)}, {3'h0, wrap});
      cmp("limit", {3'h0, e == (dn ? 4'h0 : 4'h9)}, {3'h0, limit});
      cmp("mode", {2'h0, dn ? MODE_DOWN : MODE_UP}, {2'h0, mode});
      cmp("cascade en", {3'h0, run & (e == (dn ? 4'h0 : 4'h9))}, {3'h0, casc_en});
    end
  endtask
  initial
  begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    load(4'h7);
    base = carry_lows;
    casc_base = casc_lows;
    run_steps(1'b0, 4);
    cmp("carry width", 4'(LINK_HALF_CYC), 4'(carry_lows - base));
    cmp("cascade clock", 4'(LINK_HALF_CYC), 4'(casc_lows - casc_base));
    $display("test up done");
    load(4'h9);
    base = carry_lows;
    repeat (40) @(negedge mclk);
    cmp("hold", 4'h9, count_q);
    cmp("mode hold", {2'h0, MODE_HOLD}, {2'h0, mode});
    cmp("limit idle", 4'h1, {3'h0, limit});
    cmp("stage limit", 4'h1, {3'h0, sys_limit});
    cmp("cascade gate", 4'h0, {3'h0, casc_en});
    cmp("cascade idle", 4'h1, {3'h0, casc_clk});
    cmp("carry idle", 4'h0, 4'(carry_lows - base));
    down = 1'b1;
    repeat (25) @(negedge mclk);
    cmp("limit dir", 4'h0, {3'h0, limit});
    run_steps(1'b1, 11);
    $display("test down done");
    load(4'hc);
    run_steps(1'b0, 1);
    load(4'hd);
    run_steps(1'b1, 1);
    $display("test range done");
    stop_test();
  end
endmodule // tb_top
